/* pkg/spbu_pkg.sv */
// Package for the status, protection and bank unit
// Functional notes
// [R1] Status word is 16 bits; bit 15 is the privileged-mode flag.
// [R2] Bit 14 lets fixed-point conditions raise internal interrupts.
// [R3] Bit 13 lets floating-point conditions raise internal interrupts.
// [R4] Bit 12 enables protection checks; clear means no checks.
// [R5] Bits 6..4 hold priority; bits 11..7 reserved, read zero.
// [R6] Bit 3 set on carry out of a result, else cleared.
// [R7] Bit 2 copies the result's most significant bit.
// [R8] Bit 1 set when result nonzero, cleared when zero.
// [R9] Bit 0 set when result overflowed, else cleared.
// [R10] Unprivileged device-register access or system instruction raises internal interrupt.
// [R11] Protection fitted and enabled: protected access raises internal interrupt.
// [R12] 32768 words as 128 blocks of 256, each read, write, detect bits.
// [R13] Any word written in a block sets its write-detect bit.
// [R14] Protect bits may be set only in privileged mode.
// [R15] Protection checks stay active in privileged mode.
// [R16] Checks apply to processor accesses only; DMA never blocked.
// [R17] Logical block is eight consecutive protection blocks, 2048 words.
// [R18] Priority 1,2,5,7 select banks 0,1,2,3.
// [R19] Each bank holds sixteen 16-bit registers; up to three extra banks.
// [R20] General register 15 is the system stack pointer.
// [R21] External request accepted only if level exceeds current priority.
// [R22] Unmapped priorities and missing banks select bank 0.
// [R23] Protected read or write is suppressed and flagged as violation.
package spbu_pkg;
  // ----------------------------------------
  // Status word fields
  // ----------------------------------------
  localparam int PSW_PRIV = 15;
  localparam int PSW_FIXIE = 14;
  localparam int PSW_FLTIE = 13;
  localparam int PSW_PROT = 12;
  localparam int PSW_PRI_LO = 4;
  localparam int PSW_LINK = 3;
  localparam int PSW_MOST = 2;
  localparam int PSW_NZ = 1;
  localparam int PSW_OVF = 0;
  localparam logic [15:0] PSW_RESET = 16'h8010;
  localparam logic [15:0] PSW_WMASK = 16'hf07f;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // ----------------------------------------
  // Protection geometry
  // ----------------------------------------
  localparam int BLK_BITS = 7;
  localparam int BLK_SHIFT = 8;
  localparam int LBLK_SHIFT = 3;
  localparam int WADDR_BITS = 15;
  // ----------------------------------------
  // Register port map
  // ----------------------------------------
  localparam logic [7:0] REG_PSW = 8'h00;
  localparam logic [7:0] REG_PC = 8'h01;
  localparam logic [7:0] REG_BLKSEL = 8'h02;
  localparam logic [7:0] REG_BLKBITS = 8'h03;
  localparam logic [7:0] REG_VIOL = 8'h04;
  localparam logic [7:0] REG_GPR_BASE = 8'h10;
  localparam int BIT_RP = 0;
  localparam int BIT_WP = 1;
  localparam int BIT_WD = 2;
  localparam int SP_REG = 15;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic dma;
    logic [14:0] addr;
  } spbu_access_t;
  typedef struct packed {
    logic load;
    logic carry;
    logic ovf;
    logic fix_cond;
    logic flt_cond;
    logic [15:0] value;
  } spbu_result_t;
  typedef struct packed {
    logic priv;
    logic prot;
    logic fixed;
    logic flt;
  } spbu_irq_t;
endpackage

/* src/spbu_top.sv */
// Status word, program counter, memory protection and register banks
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module spbu_top #(
  parameter int NUM_BANKS = 4,
  parameter bit PROT_FITTED = 1'b1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Execution path
  input wire spbu_pkg::spbu_access_t access_in,
  input wire logic dev_access_in,
  input wire logic sys_instr_in,
  input wire spbu_pkg::spbu_result_t result_in,
  input wire logic pc_load_in,
  input wire logic [15:0] pc_value_in,
  input wire logic psw_load_in,
  input wire logic [15:0] psw_value_in,
  input wire logic [2:0] ext_level_in,
  // Register bank read port
  input wire logic [3:0] gpr_sel_in,
  output logic [15:0] gpr_rdata_out,
  // Results
  output logic access_ok_out,
  output logic ext_accept_out,
  output logic [1:0] bank_out,
  output logic [15:0] psw_out,
  output logic [15:0] pc_out,
  output logic [15:0] stack_ptr_out,
  output spbu_pkg::spbu_irq_t irq_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] bank_of(input logic [2:0] pri);
    logic [1:0] b;
    b = 2'h0;
    unique case (pri)
      3'h2: b = 2'h1;
      3'h5: b = 2'h2;
      3'h7: b = 2'h3;
      default: b = 2'h0;
    endcase
    if (int'(b) >= NUM_BANKS) begin
      b = 2'h0;
    end
    return b;
  endfunction

  logic [15:0] psw;
  logic [15:0] pc;
  logic [2:0] blk_rp [128];
  logic [6:0] blk_sel;
  logic [15:0] gpr [NUM_BANKS*16];
  logic [1:0] bank;
  logic [2:0] pri;
  logic [6:0] acc_blk;
  logic check_on;
  logic viol;
  logic [15:0] next_psw;
  logic [15:0] viol_count;

  localparam int PSW_PRI_HI = spbu_pkg::PSW_PRI_LO + 2;
  logic [3:0] acc_lblk;
  assign pri = psw[PSW_PRI_HI:spbu_pkg::PSW_PRI_LO];
  assign bank = bank_of(pri); // see [R18] see [R22]
  assign acc_blk = access_in.addr[spbu_pkg::WADDR_BITS-1:spbu_pkg::BLK_SHIFT]; // see [R12]
  // Logical block groups eight protection blocks
  assign acc_lblk = acc_blk[6:spbu_pkg::LBLK_SHIFT]; // see [R17]
  // DMA bypasses the check; privilege does not
  assign check_on = PROT_FITTED && psw[spbu_pkg::PSW_PROT] && access_in.valid && !access_in.dma; // see [R4] see [R15] see [R16]
  assign viol = check_on && (access_in.write ? blk_rp[acc_blk][spbu_pkg::BIT_WP]
                                             : blk_rp[acc_blk][spbu_pkg::BIT_RP]); // see [R23]
  assign access_ok_out = access_in.valid && !viol; // see [R23]
  assign ext_accept_out = ext_level_in > pri; // see [R21]
  assign bank_out = bank;
  assign psw_out = psw;
  assign pc_out = pc;

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb begin
    next_psw = psw;
    if (psw_load_in) begin
      next_psw = psw_value_in & spbu_pkg::PSW_WMASK; // see [R5]
    end else if (reg_wr_in && reg_addr_in == spbu_pkg::REG_PSW) begin
      next_psw = reg_wdata_in & spbu_pkg::PSW_WMASK;
    end
    if (result_in.load) begin
      next_psw[spbu_pkg::PSW_LINK] = result_in.carry; // see [R6]
      next_psw[spbu_pkg::PSW_MOST] = result_in.value[15]; // see [R7]
      next_psw[spbu_pkg::PSW_NZ] = |result_in.value; // see [R8]
      next_psw[spbu_pkg::PSW_OVF] = result_in.ovf; // see [R9]
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      psw <= spbu_pkg::PSW_RESET;
    end else if (clk_en_in) begin
      psw <= next_psw; // see [R1]
    end
  end

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc <= spbu_pkg::PC_RESET;
    end else if (clk_en_in) begin
      if (pc_load_in) begin
        pc <= pc_value_in;
      end else if (reg_wr_in && reg_addr_in == spbu_pkg::REG_PC) begin
        pc <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------
  // Internal interrupt requests
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= '0;
    end else if (clk_en_in) begin
      irq_out.priv <= !psw[spbu_pkg::PSW_PRIV] && (dev_access_in || sys_instr_in); // see [R10]
      irq_out.prot <= viol; // see [R11]
      irq_out.fixed <= psw[spbu_pkg::PSW_FIXIE] && result_in.load && result_in.fix_cond; // see [R2]
      irq_out.flt <= psw[spbu_pkg::PSW_FLTIE] && result_in.load && result_in.flt_cond; // see [R3]
    end
  end

  // ----------------------------------------
  // Block protection bits
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      blk_sel <= 7'h00;
    end else if (clk_en_in && reg_wr_in && reg_addr_in == spbu_pkg::REG_BLKSEL) begin
      blk_sel <= reg_wdata_in[6:0];
    end
  end

  // Clearing detect by software loses to a same-cycle write hit
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 128; i++) begin
        blk_rp[i] <= 3'h0;
      end
    end else if (clk_en_in) begin
      if (reg_wr_in && reg_addr_in == spbu_pkg::REG_BLKBITS) begin
        blk_rp[blk_sel][spbu_pkg::BIT_WD] <= reg_wdata_in[spbu_pkg::BIT_WD];
        if (psw[spbu_pkg::PSW_PRIV]) begin
          blk_rp[blk_sel][1:0] <= reg_wdata_in[1:0]; // see [R14]
        end
      end
      if (access_in.valid && access_in.write && !viol) begin
        blk_rp[acc_blk][spbu_pkg::BIT_WD] <= 1'b1; // see [R13]
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      viol_count <= 16'h0000;
    end else if (clk_en_in && viol) begin
      viol_count <= viol_count + 16'h0001;
    end
  end

  // ----------------------------------------
  // General register banks
  // ----------------------------------------
  // Register file written only over the register port
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_BANKS*16; i++) begin
        gpr[i] <= 16'h0000;
      end
    end else if (clk_en_in && reg_wr_in && reg_addr_in[7:4] == spbu_pkg::REG_GPR_BASE[7:4]) begin
      gpr[{bank, reg_addr_in[3:0]}] <= reg_wdata_in; // see [R19]
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gpr_rdata_out <= 16'h0000;
      stack_ptr_out <= 16'h0000;
    end else if (clk_en_in) begin
      gpr_rdata_out <= gpr[{bank, gpr_sel_in}];
      stack_ptr_out <= gpr[{bank, 4'(spbu_pkg::SP_REG)}]; // see [R20]
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (clk_en_in) begin
      reg_rdata_out <= 16'h0000;
      if (reg_rd_in) begin
        if (reg_addr_in[7:4] == spbu_pkg::REG_GPR_BASE[7:4]) begin
          reg_rdata_out <= gpr[{bank, reg_addr_in[3:0]}];
        end else begin
          unique case (reg_addr_in)
            spbu_pkg::REG_PSW: reg_rdata_out <= psw;
            spbu_pkg::REG_PC: reg_rdata_out <= pc;
            spbu_pkg::REG_BLKSEL: reg_rdata_out <= {9'h000, blk_sel};
            spbu_pkg::REG_BLKBITS: reg_rdata_out <= {13'h0, blk_rp[blk_sel]};
            spbu_pkg::REG_VIOL: reg_rdata_out <= viol_count;
            default: reg_rdata_out <= 16'h0000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reserved_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R5]
    psw[11:7] == 5'h00) else $error("reserved status bits set");
  a_nz_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R8]
    clk_en_in && result_in.load |=> psw[1] == ($past(result_in.value) != 16'h0000))
    else $error("nonzero flag wrong");
  a_most_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R7]
    clk_en_in && result_in.load |=> psw[2] == $past(result_in.value[15])) else $error("most flag wrong");
  a_priv_irq: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R10]
    clk_en_in && !psw[15] && sys_instr_in |=> irq_out.priv) else $error("privilege trap missed");
  a_prot_off: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R4]
    !psw[12] |-> access_ok_out == access_in.valid) else $error("check active while disabled");
  a_dma_pass: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R16]
    access_in.valid && access_in.dma |-> access_ok_out) else $error("dma blocked");
  a_detect_set: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R13]
    clk_en_in && access_in.valid && access_in.write && access_ok_out
    |=> blk_rp[$past(acc_blk)][2]) else $error("write detect not set");
  a_bank_map: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R18]
    pri == 3'h7 && NUM_BANKS == 4 |-> bank_out == 2'h3) else $error("bank select wrong");
  a_ext_accept: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R21]
    ext_accept_out |-> ext_level_in > psw[6:4]) else $error("external accept wrong");
  a_lblk_group: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R17]
    access_in.valid |-> acc_lblk == access_in.addr[14:11]) else $error("logical block wrong");
endmodule

/* verification/spbu_exec_model.sv */
// Execution-path model issuing one flag-update result per request
`timescale 1ns/1ps
module spbu_exec_model (
  // Clock and request
  input wire logic clock_in,
  input wire logic go_in,
  input wire logic [19:0] pick_in,
  // Result toward the unit
  output spbu_pkg::spbu_result_t result_out = '0
);
  // ----------------------------------------
  // One-cycle result
  // ----------------------------------------
  // Idle value flips so a stale result never looks like fresh data
  always @(posedge clock_in) begin
    result_out <= {go_in, pick_in[19:16], go_in ? pick_in[15:0] : ~result_out.value};
  end
endmodule

/* verification/status_protect_bank_unit_tb_top.sv */
// Self-checking bench for the status, protection and bank unit
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module status_protect_bank_unit_tb_top;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic rd_q = 1'b0;
  logic [15:0] reg_rdata_out, gpr_rdata_out, psw_out, pc_out, stack_ptr_out, got_e, v;
  spbu_pkg::spbu_access_t access_in = '0;
  spbu_pkg::spbu_result_t result_in;
  spbu_pkg::spbu_irq_t irq_out;
  logic dev_access_in = 1'b0;
  logic sys_instr_in = 1'b0;
  logic pc_load_in = 1'b0;
  logic [15:0] pc_value_in = 16'h0000;
  logic [2:0] ext_level_in = 3'h0;
  logic access_ok_out, ext_accept_out, go;
  logic [1:0] bank_out;
  logic [19:0] pick = 20'h00000;
  logic [15:0] seed = 16'h0043;
  logic [1:0] bmap [8] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0, 2'h3};
  logic [15:0] expq [$];
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  initial go = 1'b0;
  always #4 clock_in = ~clock_in;
  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  spbu_top spbu_top_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .access_in(access_in), .dev_access_in(dev_access_in),
    .sys_instr_in(sys_instr_in), .result_in(result_in), .pc_load_in(pc_load_in), .pc_value_in(pc_value_in),
    .psw_load_in(1'b0), .psw_value_in(16'h0000), .ext_level_in(ext_level_in), .gpr_sel_in(4'hf),
    .gpr_rdata_out(gpr_rdata_out), .access_ok_out(access_ok_out), .ext_accept_out(ext_accept_out),
    .bank_out(bank_out), .psw_out(psw_out), .pc_out(pc_out), .stack_ptr_out(stack_ptr_out),
    .irq_out(irq_out));
  spbu_exec_model spbu_exec_model_inst (.clock_in(clock_in), .go_in(go), .pick_in(pick),
    .result_out(result_in));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    expq.push_back(e);
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic acc(input logic [17:0] a, input logic ok);
    @(posedge clock_in);
    access_in <= a;
    #1 `CHK("access ok", ok, access_ok_out)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clock_in) begin
    rd_q <= reg_rd_in;
    if (rd_q) begin
      got_e = expq.pop_front();
      `CHK("read data", got_e, reg_rdata_out)
    end
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    rd(8'h00, 16'h8010);
    wr(8'h00, 16'hffff);
    rd(8'h00, 16'hf07f);
    for (int p = 0; p < 8; p++) begin
      wr(8'h00, {9'h100, p[2:0], 4'h0});
      seed = lfsr(seed);
      ext_level_in <= seed[2:0];
      #1 `CHK("bank", bmap[p], bank_out)
      `CHK("ext accept", seed[2:0] > p[2:0], ext_accept_out)
      wr(8'h1f, 16'h00a0 + p[15:0]);
    end
    foreach (bmap[p]) if (p == 1 || p == 2 || p == 5 || p == 7) begin
      wr(8'h00, {9'h100, p[2:0], 4'h0});
      rd(8'h1f, p == 1 ? 16'h00a6 : 16'h00a0 + p[15:0]);
      #1 `CHK("stack ptr", p == 1 ? 16'h00a6 : 16'h00a0 + p[15:0], stack_ptr_out)
      `CHK("gpr data", p == 1 ? 16'h00a6 : 16'h00a0 + p[15:0], gpr_rdata_out)
    end
    wr(8'h00, 16'he010);
    repeat (4) begin
      seed = lfsr(seed);
      v = seed & {16{seed[1]}};
      pick <= {seed[15:12], v};
      go <= 1'b1;
      @(posedge clock_in);
      go <= 1'b0;
      @(posedge clock_in);
      #1 `CHK("fixed irq", seed[13], irq_out.fixed)
      `CHK("float irq", seed[12], irq_out.flt)
      rd(8'h00, {12'he01, seed[15], v[15], |v, seed[14]});
    end
    pc_load_in <= 1'b1;
    pc_value_in <= seed;
    @(posedge clock_in);
    pc_load_in <= 1'b0;
    #1 `CHK("pc", seed, pc_out)
    wr(8'h00, 16'h9010);
    wr(8'h02, 16'h0005);
    wr(8'h03, 16'h0003);
    rd(8'h03, 16'h0003);
    acc({3'h6, 15'h0512}, 1'b0);
    acc({3'h5, 15'h0500}, 1'b1);
    #1 `CHK("prot irq", 1'b1, irq_out.prot)
    acc({3'h4, 15'h0500}, 1'b0);
    acc({3'h6, 15'h0634}, 1'b1);
    acc(18'h00000, 1'b0);
    wr(8'h02, 16'h0006);
    rd(8'h03, 16'h0004);
    wr(8'h00, 16'h8010);
    acc({3'h4, 15'h0500}, 1'b1);
    acc(18'h00000, 1'b0);
    wr(8'h00, 16'h1010);
    wr(8'h02, 16'h0005);
    wr(8'h03, 16'h0000);
    rd(8'h03, 16'h0003);
    dev_access_in <= 1'b1;
    @(posedge clock_in);
    dev_access_in <= 1'b0;
    sys_instr_in <= 1'b1;
    #1 `CHK("priv irq", 1'b1, irq_out.priv)
    @(posedge clock_in);
    sys_instr_in <= 1'b0;
    #1 `CHK("priv irq", 1'b1, irq_out.priv)
    wr(8'h07, 16'hffff);
    rd(8'h00, 16'h1010);
    rd(8'h04, 16'h0002);
    repeat (2) @(posedge clock_in);
    report_and_stop();
  end
endmodule
